// *** rtl/config_strap_pin_mux.sv ***
// Purpose: reset strap capture and steering of the shared device pins
// Assumes: strap and pad inputs synchronous to clk_sys_i; rst_b_i asynchronous
// Notes:   pad outputs are registered; strap selections hold until the next reset
`timescale 1ns/10ps
`include "pin_mux_regs.svh"
module config_strap_pin_mux
    import pin_mux_pkg::*;
#(
    parameter int SERIAL_ONE_ONLY_W = 3,
    parameter int CELL_ONLY_W       = 8,
    parameter int PCI_ONLY_W        = 4
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_b_i,
    // straps
    input  wire logic                         host_data_bit5_strap_i,
    input  wire logic                         cell_port_enable_strap_i,
    input  wire logic                         pci_enable_strap_i,
    output logic                              host_port_wide_o,
    output logic                              cell_port_enabled_o,
    output logic                              pci_enabled_o,
    output logic                              straps_valid_o,
    // host data / PCI address-data pins
    input  wire logic [`HOST_DATA_W-1:0]      host_port_out_i,
    input  wire logic                         host_port_oe_i,
    input  wire logic [`HOST_DATA_W-1:0]      pci_ad_out_i,
    input  wire logic                         pci_ad_oe_i,
    input  wire logic [`HOST_DATA_W-1:0]      host_data_pad_i,
    output logic      [`HOST_DATA_W-1:0]      host_data_pad_o,
    output logic      [`HOST_DATA_W-1:0]      host_data_pad_oe_o,
    output logic      [`HOST_DATA_W-1:0]      host_port_in_o,
    output logic      [`HOST_DATA_W-1:0]      pci_ad_in_o,
    // GPIO 1, 2, 8 shared with clock outputs and serial-two clock
    input  wire logic                         clock_out_div_four_i,
    input  wire logic                         clock_out_div_six_i,
    output logic                              serial_two_ext_clock_o,
    input  wire logic [`CLK_GP_W-1:0]         clk_gpio_pin_enable_bit_i,
    input  wire logic [`CLK_GP_W-1:0]         clk_gpio_direction_bit_i,
    input  wire logic [`CLK_GP_W-1:0]         clk_gpio_out_i,
    output logic      [`CLK_GP_W-1:0]         clk_gpio_in_o,
    input  wire logic [`CLK_GP_W-1:0]         clk_gp_pad_i,
    output logic      [`CLK_GP_W-1:0]         clk_gp_pad_o,
    output logic      [`CLK_GP_W-1:0]         clk_gp_pad_oe_o,
    // GPIO 9 to 15 shared with PCI
    input  wire logic [`PCI_GP_W-1:0]         pci_gpio_pin_enable_bit_i,
    input  wire logic [`PCI_GP_W-1:0]         pci_gpio_direction_bit_i,
    input  wire logic [`PCI_GP_W-1:0]         pci_gpio_out_i,
    output logic      [`PCI_GP_W-1:0]         pci_gpio_in_o,
    input  wire logic [`PCI_GP_W-1:0]         pci_side_out_i,
    input  wire logic [`PCI_GP_W-1:0]         pci_side_oe_i,
    output logic      [`PCI_GP_W-1:0]         pci_side_in_o,
    input  wire logic [`PCI_GP_W-1:0]         pci_gp_pad_i,
    output logic      [`PCI_GP_W-1:0]         pci_gp_pad_o,
    output logic      [`PCI_GP_W-1:0]         pci_gp_pad_oe_o,
    // serial port one / cell port shared pins
    input  wire logic                         serial_one_tx_data_i,
    input  wire logic                         serial_one_tx_frame_i,
    input  wire logic                         serial_one_tx_frame_oe_i,
    input  wire logic                         serial_one_rx_frame_i,
    input  wire logic                         serial_one_rx_frame_oe_i,
    output logic                              serial_one_tx_frame_o,
    output logic                              serial_one_rx_frame_o,
    output logic                              serial_one_rx_data_o,
    output logic      [`SHARED_PIN_W-1:0]     cell_port_addr_o,
    input  wire logic [`SHARED_PIN_W-1:0]     shared_pad_i,
    output logic      [`SHARED_PIN_W-1:0]     shared_pad_o,
    output logic      [`SHARED_PIN_W-1:0]     shared_pad_oe_o,
    // standalone pins of each strap-gated peripheral
    input  wire logic [SERIAL_ONE_ONLY_W-1:0] serial_one_only_out_i,
    input  wire logic [SERIAL_ONE_ONLY_W-1:0] serial_one_only_oe_i,
    output logic      [SERIAL_ONE_ONLY_W-1:0] serial_one_only_pad_o,
    output logic      [SERIAL_ONE_ONLY_W-1:0] serial_one_only_pad_oe_o,
    input  wire logic [CELL_ONLY_W-1:0]       cell_only_out_i,
    input  wire logic [CELL_ONLY_W-1:0]       cell_only_oe_i,
    output logic      [CELL_ONLY_W-1:0]       cell_only_pad_o,
    output logic      [CELL_ONLY_W-1:0]       cell_only_pad_oe_o,
    input  wire logic [PCI_ONLY_W-1:0]        pci_only_out_i,
    input  wire logic [PCI_ONLY_W-1:0]        pci_only_oe_i,
    output logic      [PCI_ONLY_W-1:0]        pci_only_pad_o,
    output logic      [PCI_ONLY_W-1:0]        pci_only_pad_oe_o
);

    if (SERIAL_ONE_ONLY_W < 1 || CELL_ONLY_W < 1 || PCI_ONLY_W < 1) begin : width_check
        $error("standalone pin group widths must be at least one");
    end

    localparam logic [`HOST_DATA_W-1:0] NARROW_MASK = {{(`HOST_DATA_W-`HOST_NARROW_W){1'b0}},
                                                       {`HOST_NARROW_W{1'b1}}};

    typedef struct packed {
        strap_sel_t                     sel;
        logic [`HOST_DATA_W-1:0]        hd_out;
        logic [`HOST_DATA_W-1:0]        hd_oe;
        logic [`SHARED_PIN_W-1:0]       sh_out;
        logic [`SHARED_PIN_W-1:0]       sh_oe;
        logic [SERIAL_ONE_ONLY_W-1:0]   so_out;
        logic [SERIAL_ONE_ONLY_W-1:0]   so_oe;
        logic [CELL_ONLY_W-1:0]         co_out;
        logic [CELL_ONLY_W-1:0]         co_oe;
        logic [PCI_ONLY_W-1:0]          po_out;
        logic [PCI_ONLY_W-1:0]          po_oe;
    } mux_state_t;

    logic [1:0]               rst_sync_reg;
    logic                     rst_b;
    mux_state_t               state_reg;
    mux_state_t               state_next;
    logic [`HOST_DATA_W-1:0]  host_mask;
    logic [`CLK_GP_W-1:0]     clk_func_out;
    logic [`CLK_GP_W-1:0]     clk_func_oe;
    logic [`CLK_GP_W-1:0]     clk_func_in;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_reg[1];

    always_comb begin
        state_next = state_reg;
        // [R14] capture once after release
        if (!state_reg.sel.captured) begin
            state_next.sel.host_wide    = host_data_bit5_strap_i;
            state_next.sel.cell_port_en = cell_port_enable_strap_i;
            state_next.sel.pci_en       = pci_enable_strap_i;
            state_next.sel.captured     = 1'b1;
        end
        // [R1] [R2] host width mask
        host_mask = state_reg.sel.host_wide ? {`HOST_DATA_W{1'b1}} : NARROW_MASK;
        // [R4] one owner per strap
        if (state_reg.sel.pci_en) begin
            state_next.hd_out = pci_ad_out_i & {`HOST_DATA_W{pci_ad_oe_i}};
            state_next.hd_oe  = {`HOST_DATA_W{pci_ad_oe_i}};
        end else begin
            state_next.hd_out = host_port_out_i & host_mask & {`HOST_DATA_W{host_port_oe_i}};
            state_next.hd_oe  = host_mask & {`HOST_DATA_W{host_port_oe_i}};
        end
        // [R12] cell port takes shared pins
        if (state_reg.sel.cell_port_en) begin
            state_next.sh_out = '0;
            state_next.sh_oe  = '0;
        end else begin
            // [R10] serial one by default
            state_next.sh_out = '0;
            state_next.sh_oe  = '0;
            state_next.sh_out[`SH_TX_DATA]  = serial_one_tx_data_i;
            state_next.sh_oe[`SH_TX_DATA]   = 1'b1;
            state_next.sh_out[`SH_TX_FRAME] = serial_one_tx_frame_i & serial_one_tx_frame_oe_i;
            state_next.sh_oe[`SH_TX_FRAME]  = serial_one_tx_frame_oe_i;
            state_next.sh_out[`SH_RX_FRAME] = serial_one_rx_frame_i & serial_one_rx_frame_oe_i;
            state_next.sh_oe[`SH_RX_FRAME]  = serial_one_rx_frame_oe_i;
        end
        // [R12] [R13] standalone tie-off
        state_next.so_oe  = state_reg.sel.cell_port_en ? '0 : serial_one_only_oe_i;
        state_next.so_out = serial_one_only_out_i & state_next.so_oe;
        state_next.co_oe  = state_reg.sel.cell_port_en ? cell_only_oe_i : '0;
        state_next.co_out = cell_only_out_i & state_next.co_oe;
        state_next.po_oe  = state_reg.sel.pci_en ? pci_only_oe_i : '0;
        state_next.po_out = pci_only_out_i & state_next.po_oe;
    end

    // [R9] defaults with PCI and cell port off
    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            state_reg                  <= '0;
            state_reg.sel.host_wide    <= `HOST_WIDE_RST;
            state_reg.sel.cell_port_en <= `CELL_PORT_EN_RST;
            state_reg.sel.pci_en       <= `PCI_EN_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign host_port_wide_o         = state_reg.sel.host_wide;
    assign cell_port_enabled_o      = state_reg.sel.cell_port_en;
    assign pci_enabled_o            = state_reg.sel.pci_en;
    assign straps_valid_o           = state_reg.sel.captured;
    assign host_data_pad_o          = state_reg.hd_out;
    assign host_data_pad_oe_o       = state_reg.hd_oe;
    assign host_port_in_o           = state_reg.sel.pci_en ? '0 : (host_data_pad_i & host_mask);
    assign pci_ad_in_o              = state_reg.sel.pci_en ? host_data_pad_i : '0;
    assign shared_pad_o             = state_reg.sh_out;
    assign shared_pad_oe_o          = state_reg.sh_oe;
    assign serial_one_tx_frame_o    = state_reg.sel.cell_port_en ? 1'b0 : shared_pad_i[`SH_TX_FRAME];
    assign serial_one_rx_frame_o    = state_reg.sel.cell_port_en ? 1'b0 : shared_pad_i[`SH_RX_FRAME];
    assign serial_one_rx_data_o     = state_reg.sel.cell_port_en ? 1'b0 : shared_pad_i[`SH_RX_DATA];
    assign cell_port_addr_o         = state_reg.sel.cell_port_en ? shared_pad_i : '0;
    assign serial_one_only_pad_o    = state_reg.so_out;
    assign serial_one_only_pad_oe_o = state_reg.so_oe;
    assign cell_only_pad_o          = state_reg.co_out;
    assign cell_only_pad_oe_o       = state_reg.co_oe;
    assign pci_only_pad_o           = state_reg.po_out;
    assign pci_only_pad_oe_o        = state_reg.po_oe;

    // index 0 and 1 drive the divided clocks, index 2 is the serial-two clock input
    assign clk_func_out           = {1'b0, clock_out_div_six_i, clock_out_div_four_i};
    assign clk_func_oe            = 3'h3;
    assign serial_two_ext_clock_o = clk_func_in[2];

    // [R3] [R5] live software steering
    for (genvar i = 0; i < `CLK_GP_W; i++) begin : clk_gp
        gpio_pad_cell u_cell (
            .clk_sys_i    (clk_sys_i),
            .rst_b_i      (rst_b),
            .func_active_i(1'b1),
            .gpio_allow_i (1'b1),
            .gpio_en_i    (clk_gpio_pin_enable_bit_i[i]),
            .gpio_dir_i   (clk_gpio_direction_bit_i[i]),
            .gpio_out_i   (clk_gpio_out_i[i]),
            .func_out_i   (clk_func_out[i]),
            .func_oe_i    (clk_func_oe[i]),
            .pad_i        (clk_gp_pad_i[i]),
            .pad_o        (clk_gp_pad_o[i]),
            .pad_oe_o     (clk_gp_pad_oe_o[i]),
            .gpio_in_o    (clk_gpio_in_o[i]),
            .func_in_o    (clk_func_in[i])
        );
    end

    // [R8] GPIO only with PCI strapped off
    for (genvar i = 0; i < `PCI_GP_W; i++) begin : pci_gp
        gpio_pad_cell u_cell (
            .clk_sys_i    (clk_sys_i),
            .rst_b_i      (rst_b),
            .func_active_i(state_reg.sel.pci_en),
            .gpio_allow_i (~state_reg.sel.pci_en),
            .gpio_en_i    (pci_gpio_pin_enable_bit_i[i]),
            .gpio_dir_i   (pci_gpio_direction_bit_i[i]),
            .gpio_out_i   (pci_gpio_out_i[i]),
            .func_out_i   (pci_side_out_i[i]),
            .func_oe_i    (pci_side_oe_i[i]),
            .pad_i        (pci_gp_pad_i[i]),
            .pad_o        (pci_gp_pad_o[i]),
            .pad_oe_o     (pci_gp_pad_oe_o[i]),
            .gpio_in_o    (pci_gpio_in_o[i]),
            .func_in_o    (pci_side_in_o[i])
        );
    end

endmodule

// *** rtl/gpio_pad_cell.sv ***
// Purpose: one shared pad owned either by a peripheral function or by GPIO
// Assumes: all controls synchronous to clk_sys_i
// Notes:   pad drive is registered, so a change of owner shows one cycle later
`timescale 1ns/10ps
module gpio_pad_cell
    import pin_mux_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic func_active_i,
    input  wire logic gpio_allow_i,
    input  wire logic gpio_en_i,
    input  wire logic gpio_dir_i,
    input  wire logic gpio_out_i,
    input  wire logic func_out_i,
    input  wire logic func_oe_i,
    input  wire logic pad_i,
    output logic      pad_o,
    output logic      pad_oe_o,
    output logic      gpio_in_o,
    output logic      func_in_o
);

    typedef struct packed {
        logic pad_out;
        logic pad_oe;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;
    pad_owner_t  owner;

    always_comb begin
        // [R6] GPIO takes over
        if (gpio_en_i && gpio_allow_i) begin
            owner = PAD_GPIO;
        end else if (func_active_i) begin
            owner = PAD_FUNC;
        end else begin
            owner = PAD_OFF;
        end
        state_next = state_reg;
        unique case (owner)
            // [R7] direction selects drive
            PAD_GPIO: begin
                state_next.pad_out = gpio_out_i & gpio_dir_i;
                state_next.pad_oe  = gpio_dir_i;
            end
            PAD_FUNC: begin
                state_next.pad_out = func_out_i & func_oe_i;
                state_next.pad_oe  = func_oe_i;
            end
            PAD_OFF: begin
                state_next.pad_out = 1'b0;
                state_next.pad_oe  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pad_o     = state_reg.pad_out;
    assign pad_oe_o  = state_reg.pad_oe;
    // inputs are gated so the idle owner sees a quiet zero
    assign gpio_in_o = pad_i & (owner == PAD_GPIO);
    assign func_in_o = pad_i & (owner == PAD_FUNC);

endmodule

// *** rtl/pin_mux_pkg.sv ***
// Purpose: types shared by the strap capture and pad steering modules
// Assumes: nothing beyond SystemVerilog packages
// Notes:   constants live in pin_mux_regs.svh
package pin_mux_pkg;

    typedef enum logic [1:0] {
        PAD_FUNC,
        PAD_GPIO,
        PAD_OFF
    } pad_owner_t;

    typedef struct packed {
        logic host_wide;
        logic cell_port_en;
        logic pci_en;
        logic captured;
    } strap_sel_t;

endpackage

// *** rtl/pin_mux_regs.svh ***
// Purpose: constants for the strap capture and shared-pin steering block
// Assumes: straps are plain levels synchronous to clk_sys_i
// Notes:   positions below index the four shared serial/cell pins
//
// Overview of operation
// [R1] Width strap low: host port is 16 bits, upper sixteen data pins Hi-Z.
// [R2] Width strap high: host port is 32 bits on all data pins.
// [R3] Software-steered pins follow their enable and direction bits at any time.
// [R4] Strap-steered pins belong to exactly one peripheral from reset onward; the code drives them for the reset defaults in the cycle after capture.
// [R5] After reset, GPIO 1, 2, 8 serve clock outputs or serial clock.
// [R6] Enable bit one hands the pin to general-purpose I/O.
// [R7] Enabled GPIO pin: direction zero is input, direction one drives output.
// [R8] GPIO 9 to 15 work only with PCI strapped off and bits set.
// [R9] GPIO 9 to 15 idle after reset; PCI disabled by default.
// [R10] Cell port strap defaults to zero; shared pins serve serial port one.
// [R11] External controller holds non-configuration address pins at defaults or undriven.
// [R12] Cell port strapped on: shared pins serve it, serial-one-only pins Hi-Z.
// [R13] Peripheral strapped off: its standalone pins are tied off Hi-Z.
// [R14] Straps captured once at reset release and held until next reset.
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

`define HOST_DATA_W       32
`define HOST_NARROW_W     16
`define SHARED_PIN_W      4
`define CLK_GP_W          3
`define PCI_GP_W          7

// shared serial pin positions
`define SH_TX_DATA        0
`define SH_TX_FRAME       1
`define SH_RX_FRAME       2
`define SH_RX_DATA        3

// strap defaults before capture
`define HOST_WIDE_RST     1'b0
`define CELL_PORT_EN_RST  1'b0
`define PCI_EN_RST        1'b0
`define GPIO_EN_RST       1'b0

`endif

// *** verification/config_strap_pin_mux_props.sv ***
// Purpose: concurrent checks on strap capture and shared-pin steering
// Assumes: bound to config_strap_pin_mux, one clock domain
// Notes:   pad checks wait two valid cycles so $past never reaches into reset
`timescale 1ns/10ps
`include "pin_mux_regs.svh"
module config_strap_pin_mux_props
    import pin_mux_pkg::*;
#(
    parameter int SERIAL_ONE_ONLY_W = 3,
    parameter int CELL_ONLY_W       = 8,
    parameter int PCI_ONLY_W        = 4
) (
    input wire logic                         clk_sys_i,
    input wire logic                         rst_b_i,
    input wire logic                         straps_valid_o,
    input wire logic                         host_port_wide_o,
    input wire logic                         cell_port_enabled_o,
    input wire logic                         pci_enabled_o,
    input wire logic                         host_port_oe_i,
    input wire logic [`HOST_DATA_W-1:0]      host_data_pad_oe_o,
    input wire logic [`CLK_GP_W-1:0]         clk_gpio_pin_enable_bit_i,
    input wire logic [`CLK_GP_W-1:0]         clk_gpio_direction_bit_i,
    input wire logic                         clock_out_div_four_i,
    input wire logic [`CLK_GP_W-1:0]         clk_gp_pad_o,
    input wire logic [`CLK_GP_W-1:0]         clk_gp_pad_oe_o,
    input wire logic [`PCI_GP_W-1:0]         pci_gpio_pin_enable_bit_i,
    input wire logic [`PCI_GP_W-1:0]         pci_gpio_direction_bit_i,
    input wire logic [`PCI_GP_W-1:0]         pci_side_oe_i,
    input wire logic [`PCI_GP_W-1:0]         pci_gp_pad_oe_o,
    input wire logic [SERIAL_ONE_ONLY_W-1:0] serial_one_only_pad_oe_o,
    input wire logic [CELL_ONLY_W-1:0]       cell_only_pad_oe_o,
    input wire logic [PCI_ONLY_W-1:0]        pci_only_pad_oe_o,
    input wire logic [`SHARED_PIN_W-1:0]     shared_pad_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_run;
        straps_valid_o ##1 straps_valid_o;
    endsequence

    a_narrow_upper_off: assert property (s_run ##0 (!host_port_wide_o && !pci_enabled_o)
        |-> host_data_pad_oe_o[31:16] == 16'h0000)
        else $error("upper host pins driven in narrow mode");
    a_wide_all_drive: assert property (s_run ##0 (host_port_wide_o && !pci_enabled_o)
        |-> host_data_pad_oe_o == {32{$past(host_port_oe_i)}})
        else $error("wide host port enables wrong");
    a_clk_gpio_owner: assert property (s_run |-> clk_gp_pad_oe_o == (($past(clk_gpio_pin_enable_bit_i)
        & $past(clk_gpio_direction_bit_i)) | (~$past(clk_gpio_pin_enable_bit_i) & 3'h3)))
        else $error("clock gpio pad enable wrong");
    a_clk_default_out: assert property (s_run ##0 !$past(clk_gpio_pin_enable_bit_i[0])
        |-> clk_gp_pad_o[0] == $past(clock_out_div_four_i))
        else $error("default clock output not passed");
    a_pci_gpio_gate: assert property (s_run ##0 !pci_enabled_o |-> pci_gp_pad_oe_o ==
        ($past(pci_gpio_pin_enable_bit_i) & $past(pci_gpio_direction_bit_i)))
        else $error("pci gpio enable wrong");
    a_pci_owns_pins: assert property (s_run ##0 pci_enabled_o
        |-> pci_gp_pad_oe_o == $past(pci_side_oe_i))
        else $error("pci side lost its pins");
    a_strap_hold: assert property (s_run |-> $stable(host_port_wide_o) && $stable(cell_port_enabled_o)
        && $stable(pci_enabled_o))
        else $error("captured strap changed");
    a_cell_ties_serial: assert property (s_run ##0 cell_port_enabled_o
        |-> serial_one_only_pad_oe_o == '0 && shared_pad_oe_o == 4'h0)
        else $error("serial pins driven while cell port owns");
    a_off_ties_pins: assert property (s_run |-> (cell_port_enabled_o || cell_only_pad_oe_o == '0)
        && (pci_enabled_o || pci_only_pad_oe_o == '0))
        else $error("disabled peripheral drives its pins");
    a_serial_default: assert property (s_run ##0 !cell_port_enabled_o
        |-> shared_pad_oe_o[0] && !shared_pad_oe_o[3])
        else $error("serial one tx data not driven");
endmodule

bind config_strap_pin_mux config_strap_pin_mux_props #(
    .SERIAL_ONE_ONLY_W(SERIAL_ONE_ONLY_W),
    .CELL_ONLY_W(CELL_ONLY_W),
    .PCI_ONLY_W(PCI_ONLY_W)
) u_props (.*);

// *** verification/config_strap_pin_mux_tb.sv ***
// Purpose: self-checking bench for strap capture and shared-pin steering
// Assumes: default group widths of the design
// Notes:   every strap combination gets a reset and a burst of random pin traffic
`timescale 1ns/10ps
`include "pin_mux_regs.svh"
module config_strap_pin_mux_tb
    import pin_mux_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    wire logic   rst_b_i, host_data_bit5_strap_i, cell_port_enable_strap_i, pci_enable_strap_i;
    logic        host_port_oe_i, pci_ad_oe_i, clock_out_div_four_i, clock_out_div_six_i;
    logic        serial_one_tx_data_i, serial_one_tx_frame_i, serial_one_tx_frame_oe_i;
    logic        serial_one_rx_frame_i, serial_one_rx_frame_oe_i;
    logic [31:0] host_port_out_i, pci_ad_out_i, host_data_pad_i;
    logic [2:0]  clk_gpio_pin_enable_bit_i, clk_gpio_direction_bit_i, clk_gpio_out_i, clk_gp_pad_i;
    logic [6:0]  pci_gpio_pin_enable_bit_i, pci_gpio_direction_bit_i, pci_gpio_out_i;
    logic [6:0]  pci_side_out_i, pci_side_oe_i, pci_gp_pad_i;
    logic [3:0]  shared_pad_i, cell_port_addr_o, shared_pad_o, shared_pad_oe_o;
    logic [2:0]  serial_one_only_out_i, serial_one_only_oe_i, serial_one_only_pad_o, serial_one_only_pad_oe_o;
    logic [7:0]  cell_only_out_i, cell_only_oe_i, cell_only_pad_o, cell_only_pad_oe_o;
    logic [3:0]  pci_only_out_i, pci_only_oe_i, pci_only_pad_o, pci_only_pad_oe_o;
    logic        host_port_wide_o, cell_port_enabled_o, pci_enabled_o, straps_valid_o;
    logic        serial_two_ext_clock_o, serial_one_tx_frame_o, serial_one_rx_frame_o, serial_one_rx_data_o;
    logic [31:0] host_data_pad_o, host_data_pad_oe_o, host_port_in_o, pci_ad_in_o;
    logic [2:0]  clk_gpio_in_o, clk_gp_pad_o, clk_gp_pad_oe_o;
    logic [6:0]  pci_gpio_in_o, pci_side_in_o, pci_gp_pad_o, pci_gp_pad_oe_o;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    strap_board_model u_board (.clk_sys_i(clk_sys_i), .rst_b_o(rst_b_i),
        .strap_o({pci_enable_strap_i, cell_port_enable_strap_i, host_data_bit5_strap_i}));

    config_strap_pin_mux u_dut (.*);

    task automatic put(input logic [192:0] v);
        {host_port_out_i, pci_ad_out_i, host_data_pad_i, host_port_oe_i, pci_ad_oe_i, clock_out_div_four_i,
         clock_out_div_six_i, serial_one_tx_data_i, serial_one_tx_frame_i, serial_one_tx_frame_oe_i,
         serial_one_rx_frame_i, serial_one_rx_frame_oe_i, clk_gpio_pin_enable_bit_i, clk_gpio_direction_bit_i,
         clk_gpio_out_i, clk_gp_pad_i, pci_gpio_pin_enable_bit_i, pci_gpio_direction_bit_i, pci_gpio_out_i,
         pci_side_out_i, pci_side_oe_i, pci_gp_pad_i, shared_pad_i, serial_one_only_out_i, serial_one_only_oe_i,
         cell_only_out_i, cell_only_oe_i, pci_only_out_i, pci_only_oe_i} <= v;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // enable one hands the pin to gpio; otherwise the default function's drive applies
    function automatic logic [6:0] gp_oe(input logic [6:0] en, input logic [6:0] dir, input logic [6:0] dflt);
        return (en & dir) | (~en & dflt);
    endfunction

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        logic [2:0]   cfg;
        logic [223:0] rnd;
        logic [31:0]  e_hoe, e_hd, mask;
        logic [2:0]   e_coe, e_c;
        logic [6:0]   e_poe;
        logic [3:0]   e_sh;
        logic [14:0]  e_grp;
        void'($urandom(86));
        put('0);
        for (int c = 0; c < 8; c++) begin
            cfg = 3'(c);
            u_board.apply_reset(cfg);
            repeat (3) @(posedge clk_sys_i);
            mask = (cfg[2] || cfg[0]) ? 32'hFFFFFFFF : 32'h0000FFFF;
            for (int i = 0; i < 30; i++) begin
                @(posedge clk_sys_i);
                e_hoe = cfg[2] ? {32{pci_ad_oe_i}} : ({32{host_port_oe_i}} & mask);
                e_hd = cfg[2] ? pci_ad_out_i : host_port_out_i;
                e_coe = 3'(gp_oe(7'(clk_gpio_pin_enable_bit_i), 7'(clk_gpio_direction_bit_i), 7'h03));
                e_c = (clk_gpio_pin_enable_bit_i & clk_gpio_out_i)
                    | (~clk_gpio_pin_enable_bit_i & {1'b0, clock_out_div_six_i, clock_out_div_four_i});
                e_poe = cfg[2] ? pci_side_oe_i : gp_oe(pci_gpio_pin_enable_bit_i, pci_gpio_direction_bit_i, 7'h00);
                e_sh = cfg[1] ? 4'h0 : {1'b0, serial_one_rx_frame_oe_i, serial_one_tx_frame_oe_i, 1'b1};
                e_grp = {cfg[1] ? 3'h0 : serial_one_only_oe_i, cfg[1] ? cell_only_oe_i : 8'h00,
                         cfg[2] ? pci_only_oe_i : 4'h0};
                rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
                // corner cases: every request raised at once, then all dropped
                if (i % 5 == 0)
                    rnd = '1;
                else if (i % 5 == 1)
                    rnd = '0;
                put(rnd[192:0]);
                #1;
                chk({host_port_wide_o, cell_port_enabled_o, pci_enabled_o, straps_valid_o}, {cfg[0], cfg[1], cfg[2], 1'b1});
                chk(host_data_pad_oe_o, e_hoe);
                chk(host_data_pad_o & e_hoe, e_hd & e_hoe);
                chk(host_port_in_o, cfg[2] ? 32'h0 : (host_data_pad_i & mask));
                chk(clk_gp_pad_oe_o, e_coe);
                chk(clk_gp_pad_o & e_coe, e_c & e_coe);
                chk(pci_gp_pad_oe_o, e_poe);
                chk(shared_pad_oe_o, e_sh);
                chk(cell_port_addr_o, cfg[1] ? shared_pad_i : 4'h0);
                chk(pci_ad_in_o, cfg[2] ? host_data_pad_i : 32'h0);
                chk(pci_side_in_o, cfg[2] ? pci_gp_pad_i : 7'h0);
                chk(pci_gpio_in_o, cfg[2] ? 7'h0 : (pci_gp_pad_i & pci_gpio_pin_enable_bit_i));
                chk(clk_gpio_in_o, clk_gp_pad_i & clk_gpio_pin_enable_bit_i);
                chk(serial_two_ext_clock_o, clk_gp_pad_i[2] & ~clk_gpio_pin_enable_bit_i[2]);
                chk({serial_one_rx_data_o, serial_one_rx_frame_o, serial_one_tx_frame_o},
                    cfg[1] ? 3'h0 : shared_pad_i[3:1]);
                chk({serial_one_only_pad_oe_o, cell_only_pad_oe_o, pci_only_pad_oe_o}, e_grp);
            end
        end
        end_of_test();
    end
endmodule

// *** verification/strap_board_model.sv ***
// Purpose: board side of the straps: pull resistors and the reset controller
// Assumes: driven from the bench through apply_reset
// Notes:   after capture the strap pins carry other traffic, shown here as inverted levels
`timescale 1ns/10ps
module strap_board_model (
    input  wire logic       clk_sys_i,
    output logic            rst_b_o,
    output logic [2:0]      strap_o
);
    initial begin
        rst_b_o = 1'b0;
        strap_o = 3'h0;
    end

    // strap order is {pci, cell port, host width}
    task automatic apply_reset(input logic [2:0] cfg);
        @(posedge clk_sys_i);
        rst_b_o <= 1'b0;
        strap_o <= cfg;
        repeat (8) @(posedge clk_sys_i);
        rst_b_o <= 1'b1;
        // levels must survive the synchroniser and the capture edge
        repeat (4) @(posedge clk_sys_i);
        strap_o <= ~cfg;
    endtask
endmodule
